// *** src/bhp_power_handshake.sv ***
// bluetooth host power handshake and rf power-down sequencer
// Functional notes
// - asserted host wake request keeps the device fully awake
// - deasserted host wake request allows sleep only with internal sleep criteria met
// - software-set polarity for host wake input and device wake output
// - device wake output asserted while device needs host attention, held low until configured
// - clock request high when bluetooth or wlan needs reference clock, held low until configured
// - pad function select zero routes the handshake pins
// - separate power-down controls for tx, rx, pll and pa
// - power actions from software register writes or packet handling
// - handshake acts only in uart transport with handshake enabled
// - power-on reset held while regulator enable is low
`timescale 1ns/1ns
`include "bhp_cfg.svh"
module bhp_power_handshake (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// regulator enable pin, asynchronous
	input wire logic bluetooth_regulator_enable,
	// handshake pins
	input wire logic host_to_device_wake_request,
	output logic device_to_host_wake_request,
	output logic clk_req,
	// configuration
	input wire logic cfg_valid,
	input wire logic uart_mode,
	input wire logic handshake_enable,
	input wire logic host_wake_in_active_low,
	input wire logic dev_wake_out_active_low,
	input wire logic [1:0] pad_func_select,
	// internal demands
	input wire logic sleep_criteria_met,
	input wire logic need_host,
	input wire logic wlan_clk_need,
	input wire logic bt_clk_need,
	// rf power-down requests: software and baseband packet handling
	input wire bhp_pkg::bhp_rf_t sw_rf_pd,
	input wire bhp_pkg::bhp_rf_t pkt_rf_pd,
	// status and radio controls
	output logic por_active,
	output logic device_awake,
	output logic tx_pd,
	output logic rx_pd,
	output logic pll_pd,
	output logic pa_pd
);
	import bhp_pkg::*;

	logic host_wake_sync;
	logic reg_en_sync;
	bhp_state_e state;
	bhp_state_e next_state;
	logic [7:0] guard_cnt;
	logic [7:0] next_guard_cnt;
	logic next_por_active;
	logic next_device_awake;
	logic next_dev_wake;
	logic next_clk_req;
	bhp_rf_t next_rf_pd;
	bhp_rf_t rf_pd;
	// handshake qualified by transport mode, enable and pad function
	logic hs_active;
	// host wake request after synchronisation and polarity correction
	logic host_wants;
	// merged software and packet power-down lanes, one bit per radio block
	bhp_rf_t merged_pd;

	// wake test shared by the guard and sleep states
	// keeping it in one place stops the two states from drifting apart
	function automatic logic must_wake(input logic wants, input logic crit, input logic need);
		must_wake = wants || !crit || need;
	endfunction

	// host wake pin through two flops before any decision
	bhp_sync u_host_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in(host_to_device_wake_request),
		.sync_out(host_wake_sync)
	);

	// regulator enable is a pin too, so it is synchronised likewise
	bhp_sync u_reg_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in(bluetooth_regulator_enable),
		.sync_out(reg_en_sync)
	);

	// handshake qualification and input polarity
	always_comb begin
		hs_active = uart_mode && handshake_enable && (pad_func_select == `BHP_PAD_FUNC_HANDSHAKE);
		host_wants = hs_active && (host_wake_sync ^ host_wake_in_active_low);
	end

	// sleep state machine; a guard delay avoids flapping on short wake glitches
	always_comb begin
		next_state = state;
		next_guard_cnt = guard_cnt;
		next_por_active = !reg_en_sync;
		case (state)
			// outputs stay quiet here until the host side has set us up
			BHP_ST_UNCONF: begin
				if (cfg_valid && reg_en_sync) begin
					next_state = BHP_ST_AWAKE;
				end
			end
			// fully awake; leave only when nobody wants us up
			BHP_ST_AWAKE: begin
				if (!host_wants && sleep_criteria_met && !need_host) begin
					next_state = BHP_ST_GUARD;
					next_guard_cnt = 8'(`BHP_SLEEP_GUARD_CYC);
				end
			end
			// guard delay: any wake reason during the count aborts the sleep
			// the cost is a short extra awake time before every sleep
			BHP_ST_GUARD: begin
				if (must_wake(host_wants, sleep_criteria_met, need_host)) begin
					next_state = BHP_ST_AWAKE;
				end else if (guard_cnt == 8'h00) begin
					next_state = BHP_ST_SLEEP;
				end else begin
					next_guard_cnt = guard_cnt - 8'h01;
				end
			end
			// asleep with the radio powered down; wake on the first reason
			BHP_ST_SLEEP: begin
				if (must_wake(host_wants, sleep_criteria_met, need_host)) begin
					next_state = BHP_ST_AWAKE;
				end
			end
			default: begin
				next_state = BHP_ST_UNCONF;
			end
		endcase
		// losing the regulator or the configuration overrides every state
		if (!reg_en_sync || !cfg_valid) begin
			next_state = BHP_ST_UNCONF;
		end
	end

	// per-lane power-down merge; either source may shut one radio block down
	// a lane is never forced on here, sleep handling below only adds power-downs
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign merged_pd[lane] = sw_rf_pd[lane] | pkt_rf_pd[lane];
		end
	endgenerate

	// output values; device wake and clock request stay low until configured
	always_comb begin
		next_device_awake = (next_state != BHP_ST_SLEEP);
		next_dev_wake = 1'b0;
		next_clk_req = 1'b0;
		if (next_state != BHP_ST_UNCONF) begin
			next_dev_wake = (hs_active && need_host) ^ dev_wake_out_active_low;
			next_clk_req = bt_clk_need || wlan_clk_need;
		end
		// either source may power down a block; sleep powers all down
		next_rf_pd = merged_pd;
		if (next_state == BHP_ST_SLEEP || next_state == BHP_ST_UNCONF) begin
			next_rf_pd = 4'hF;
		end
	end

	// state and every top-level output registered together
	// reset values keep the host wake and clock request low and the radio off
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= BHP_ST_UNCONF;
			guard_cnt <= 8'h00;
			por_active <= 1'b1;
			device_awake <= 1'b1;
			device_to_host_wake_request <= 1'b0;
			clk_req <= 1'b0;
			rf_pd <= 4'hF;
		end else begin
			state <= next_state;
			guard_cnt <= next_guard_cnt;
			por_active <= next_por_active;
			device_awake <= next_device_awake;
			device_to_host_wake_request <= next_dev_wake;
			clk_req <= next_clk_req;
			rf_pd <= next_rf_pd;
		end
	end

	// radio power-down lines straight from the register
	always_comb begin
		tx_pd = rf_pd[`BHP_RF_TX];
		rx_pd = rf_pd[`BHP_RF_RX];
		pll_pd = rf_pd[`BHP_RF_PLL];
		pa_pd = rf_pd[`BHP_RF_PA];
	end
endmodule

// *** src/bhp_cfg.svh ***
// timing counts, reset values and field encodings for the host power handshake
`ifndef BHP_CFG_SVH
`define BHP_CFG_SVH
`define BHP_CLK_HZ 20000000
`define BHP_PAD_FUNC_HANDSHAKE 2'h0
`define BHP_POL_RESET 1'b1
`define BHP_SLEEP_GUARD_NS 1000
`define BHP_SLEEP_GUARD_CYC ((`BHP_SLEEP_GUARD_NS * 20) / 1000)
`define BHP_RF_TX 0
`define BHP_RF_RX 1
`define BHP_RF_PLL 2
`define BHP_RF_PA 3
`endif

// *** src/bhp_pkg.sv ***
// types shared by the host power handshake design
package bhp_pkg;
	typedef enum logic [3:0] {
		BHP_ST_UNCONF = 4'h1,
		BHP_ST_AWAKE = 4'h2,
		BHP_ST_GUARD = 4'h4,
		BHP_ST_SLEEP = 4'h8
	} bhp_state_e;
	typedef logic [3:0] bhp_rf_t;
endpackage

// *** src/bhp_sync.sv ***
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module bhp_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic meta;
	logic next_meta;
	logic next_sync_out;

	// the first stage feeds only the second stage
	always_comb begin
		next_meta = async_in;
		next_sync_out = meta;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= next_meta;
			sync_out <= next_sync_out;
		end
	end
endmodule

// *** sim/bhp_power_handshake_sva.sv ***
// port checker for the host power handshake
`timescale 1ns/1ns
module bhp_power_handshake_sva (
	// watched ports
	input wire logic mclk, reset_n, bluetooth_regulator_enable, host_to_device_wake_request,
	input wire logic device_to_host_wake_request, clk_req, cfg_valid, uart_mode,
	input wire logic handshake_enable, host_wake_in_active_low, dev_wake_out_active_low,
	input wire logic [1:0] pad_func_select,
	input wire logic sleep_criteria_met, need_host, bt_clk_need, por_active, device_awake,
	input wire logic tx_pd, pa_pd,
	input wire bhp_pkg::bhp_rf_t sw_rf_pd, pkt_rf_pd
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// five samples cover two sync flops, the state update and the output register
	wire on = cfg_valid && bluetooth_regulator_enable && uart_mode;
	wire hs = on && handshake_enable && pad_func_select == 2'h0;
	wire pol = dev_wake_out_active_low;
	wire dw = device_to_host_wake_request;
	sequence s_host; (hs && host_to_device_wake_request != host_wake_in_active_low)[*5]; endsequence
	property p_awake; s_host |-> device_awake; endproperty
	a_awake: assert property (p_awake) else $error("awake");
	property p_sleep; $fell(device_awake) |-> $past(sleep_criteria_met) && !$past(need_host); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep");
	property p_dw; (hs && need_host && $stable(pol))[*5] |-> dw != pol; endproperty
	a_dw: assert property (p_dw) else $error("wake out");
	property p_ref; (on && !hs && $stable(pol))[*5] |-> dw == pol; endproperty
	a_ref: assert property (p_ref) else $error("refused");
	property p_clk; (on && bt_clk_need)[*5] |-> clk_req; endproperty
	a_clk: assert property (p_clk) else $error("clk req");
	property p_unc; !cfg_valid [*3] |-> !clk_req && !dw; endproperty
	a_unc: assert property (p_unc) else $error("unconf");
	property p_por; !bluetooth_regulator_enable [*3] |-> por_active; endproperty
	a_por: assert property (p_por) else $error("por");
	property p_rf; $past(sw_rf_pd[0]) && $past(pkt_rf_pd[3]) |-> tx_pd && pa_pd; endproperty
	a_rf: assert property (p_rf) else $error("rf pd");
endmodule
bind bhp_power_handshake bhp_power_handshake_sva u_bhp_power_handshake_sva (.*);

// *** sim/bhp_host_model.sv ***
// host processor model on the far side of the handshake pins
`timescale 1ns/1ns
module bhp_host_model (
	// pins and host intent
	input wire logic mclk, dev_wake, dev_pol, pol, want, clk_req,
	output logic wake_pin, host_awake, ref_on
);
	initial wake_pin = 1'b0;
	// pin moves just after an edge; host stays up while the device calls
	always @(posedge mclk) begin
		wake_pin <= want ^ pol;
		host_awake <= (dev_wake ^ dev_pol) | want;
	end
	assign ref_on = clk_req;
endmodule

// *** sim/tb_bhp_power_handshake.sv ***
// self-checking bench for the host power handshake
`timescale 1ns/1ns
module tb_bhp_power_handshake;
	logic mclk = 0, reset_n = 0, bluetooth_regulator_enable = 0, cfg_valid = 0, uart_mode = 0;
	logic handshake_enable = 0, host_wake_in_active_low = 0, dev_wake_out_active_low = 0;
	logic sleep_criteria_met = 0, need_host = 0, wlan_clk_need = 0, bt_clk_need = 0, want = 0;
	logic [1:0] pad_func_select = 2'h0;
	bhp_pkg::bhp_rf_t sw_rf_pd = 4'h1, pkt_rf_pd = 4'h8;
	logic host_to_device_wake_request, device_to_host_wake_request, clk_req, por_active;
	logic device_awake, tx_pd, rx_pd, pll_pd, pa_pd, host_awake;
	int errors = 0, num_checks = 0;
	always #25 mclk = ~mclk;
	bhp_power_handshake u_bhp_power_handshake (.*);
	bhp_host_model u_bhp_host_model (.mclk(mclk), .dev_wake(device_to_host_wake_request),
		.dev_pol(dev_wake_out_active_low), .pol(host_wake_in_active_low), .want(want),
		.clk_req(clk_req), .wake_pin(host_to_device_wake_request), .host_awake(host_awake),
		.ref_on());
	// case equality so an unknown never matches
	task chk(input logic [7:0] a, input logic [7:0] e);
		num_checks++;
		if (a !== e) begin
			errors++;
			$display("wrong value at %0t: mismatch", $time);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task stop_test;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// tests need about 133 cycles, so 2000 means a hang
	initial begin
		step(2000);
		errors++;
		stop_test;
	end
	// test sequence
	initial begin
		step(8);
		reset_n <= 1;
		bt_clk_need <= 1;
		step(4);
		chk({por_active, clk_req}, 8'h02);
		bluetooth_regulator_enable <= 1;
		step(6);
		chk({por_active, clk_req}, 8'h00);
		{cfg_valid, uart_mode, handshake_enable, need_host} <= 4'hF;
		step(6);
		chk({clk_req, device_to_host_wake_request, host_awake}, 8'h07);
		dev_wake_out_active_low <= 1;
		step(4);
		chk({device_to_host_wake_request, tx_pd, rx_pd, pll_pd, pa_pd}, 8'h09);
		need_host <= 0;
		sleep_criteria_met <= 1;
		step(40);
		chk({device_awake, rx_pd, host_awake}, 8'h02);
		want <= 1;
		step(2);
		chk(device_awake, 8'h00);
		step(3);
		chk(device_awake, 8'h01);
		want <= 0;
		host_wake_in_active_low <= 1;
		step(40);
		chk(device_awake, 8'h00);
		handshake_enable <= 0;
		need_host <= 1;
		step(5);
		chk(device_to_host_wake_request, 8'h01);
		handshake_enable <= 1;
		pad_func_select <= 2'h1;
		step(5);
		chk(device_to_host_wake_request, 8'h01);
		bt_clk_need <= 0;
		wlan_clk_need <= 1;
		step(5);
		chk(clk_req, 8'h01);
		cfg_valid <= 0;
		step(5);
		chk({clk_req, device_to_host_wake_request, tx_pd}, 8'h01);
		stop_test;
	end
endmodule
